// *** dv/crma_ctrl_tb.sv ***
// self-checking bench for the configuration message controller
`timescale 1ns/1ps
module crma_ctrl_tb;
    logic clock, srst, cmd_valid, cmd_ready, tx_valid, tx_ready, rx_valid, rx_ready;
    logic rsp_valid, rsp_ready, slow, nak;
    crma_pkg::crma_cmd_s cmd;
    crma_pkg::crma_tok_s tx_tok, rx_tok, seen[$];
    crma_pkg::crma_res_s rsp, r;
    logic [31:0]         tx_dest, seen_dest;
    int                  n_errors, checks;

    crma_ctrl i_dut (.clock(clock), .srst(srst), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .tx_tok(tx_tok), .tx_dest(tx_dest), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_tok(rx_tok),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rsp(rsp), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));
    crma_dev_model i_dev (.clock(clock), .srst(srst), .tx_tok(tx_tok), .tx_dest(tx_dest), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_tok(rx_tok), .rx_valid(rx_valid), .rx_ready(rx_ready), .slow(slow), .nak(nak));

    // -----------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // hold the command until the edge after ready is seen
    task automatic issue(input logic [2:0] op, input logic [15:0] tg, input logic [7:0] pe,
                         input logic [23:0] rid, input logic [15:0] rg, input logic [31:0] d, input logic [7:0] sz);
        int k;
        @(negedge clock);
        seen.delete();
        cmd       <= '{crma_pkg::crma_op_e'(op), tg, pe, rid, rg, d, sz};
        cmd_valid <= 1'b1;
        for (k = 0; k < 300 && cmd_ready !== 1'b1; k++) @(negedge clock);
        chk("cmd_ready", 1, cmd_ready);
        @(negedge clock);
        cmd_valid <= 1'b0;
    endtask

    task automatic get_rsp();
        int k;
        @(negedge clock);
        for (k = 0; k < 400 && rsp_valid !== 1'b1; k++) @(negedge clock);
        chk("rsp_valid", 1, rsp_valid);
        r = rsp;
        rsp_ready <= 1'b1;
        @(negedge clock);
        rsp_ready <= 1'b0;
    endtask

    // compare the captured message, multi-byte fields most significant first
    task automatic chk_msg(input logic [7:0] lead, input logic [23:0] rid, input logic [47:0] body,
                           input int nb, input logic [31:0] dest);
        chk("length", nb + 5, seen.size());
        chk("dest", dest, seen_dest);
        if (seen.size() == nb + 5)
        begin
            chk("lead", {1'b1, lead}, seen[0]);
            for (int i = 0; i < 3; i++) chk("reply id", {1'b0, rid[23-8*i -: 8]}, seen[1+i]);
            for (int i = 0; i < nb; i++) chk("field", {1'b0, body[47-8*i -: 8]}, seen[4+i]);
            chk("close", {1'b1, crma_pkg::TOK_END}, seen[4+nb]);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_tile();
        issue(0, 16'h0012, 8'h00, 24'h0a0b0c, 16'h0105, 32'h12345678, 8'h00);
        get_rsp();
        chk_msg(crma_pkg::TOK_WR, 24'h0a0b0c, {16'h0105, 32'h12345678}, 6, 32'h0012c20c);
        chk("write ok", 1, r.ok);
        issue(1, 16'h0012, 8'h00, 24'h0a0b0c, 16'h0105, 32'h0, 8'h00);
        get_rsp();
        chk_msg(crma_pkg::TOK_RD, 24'h0a0b0c, {16'h0105, 32'h0}, 2, 32'h0012c20c);
        chk("read data", 32'h12345678, r.data);
        $display("test tile done");
    endtask

    // node traffic over a stalling link
    task automatic t_node();
        slow = 1'b1;
        issue(2, 16'h7e01, 8'h00, 24'h123456, 16'hff05, 32'ha5c30f1e, 8'h00);
        get_rsp();
        chk_msg(crma_pkg::TOK_WR, 24'h123456, {16'hff05, 32'ha5c30f1e}, 6, 32'h7e01c30c);
        issue(3, 16'h7e01, 8'h00, 24'h123456, 16'hff05, 32'h0, 8'h00);
        get_rsp();
        chk("node ok", 1, r.ok);
        chk("node data", 32'ha5c30f1e, r.data);
        slow = 1'b0;
        $display("test node done");
    endtask

    task automatic t_periph();
        issue(4, 16'h0034, 8'h56, 24'h00aa01, 16'h0021, 32'h0, 8'h04);
        get_rsp();
        chk_msg(crma_pkg::TOK_PRD, 24'h00aa01, {8'h21, 8'h04, 32'h0}, 2, 32'h00345602);
        chk("periph data", 32'h21202322, r.data);
        issue(4, 16'h0034, 8'h56, 24'h00aa01, 16'h0021, 32'h0, 8'h02);
        get_rsp();
        chk("short ok", 1, r.ok);
        chk("short data", 32'h00002322, r.data);
        $display("test periph done");
    endtask

    // suppressed write gives no result, then readback proves it landed
    task automatic t_noreply();
        issue(0, 16'h0012, 8'h00, 24'h0a0bff, 16'h0003, 32'hcafe0001, 8'h00);
        repeat (60)
        begin
            @(negedge clock);
            chk("no result", 0, rsp_valid);
        end
        chk_msg(crma_pkg::TOK_WR, 24'h0a0bff, {16'h0003, 32'hcafe0001}, 6, 32'h0012c20c);
        issue(1, 16'h0012, 8'h00, 24'h0a0b01, 16'h0003, 32'h0, 8'h00);
        get_rsp();
        chk("after quiet", 32'hcafe0001, r.data);
        $display("test noreply done");
    endtask

    task automatic t_fail();
        nak = 1'b1;
        for (int op = 0; op < 5; op++)
        begin
            issue(op[2:0], 16'h0012, 8'h56, 24'h0a0b0c, 16'h0002, 32'h1, 8'h04);
            get_rsp();
            chk("failed", 0, r.ok);
        end
        nak = 1'b0;
        issue(3'h7, 16'h0012, 8'h00, 24'h0a0b0c, 16'h0002, 32'h0, 8'h00);
        get_rsp();
        chk("bad op", 0, r.ok);
        $display("test fail done");
    endtask

    // status ids stall on a full result fifo, then drain in order
    task automatic t_fifo();
        for (int i = 0; i < 9; i++) issue(5, 16'h0, 8'h0, 24'h0, 16'h0010 + i[15:0], 32'h0, 8'h0);
        repeat (4) @(negedge clock);
        chk("stall", 0, cmd_ready);
        chk("no tokens", 0, seen.size());
        for (int i = 0; i < 9; i++)
        begin
            get_rsp();
            chk("ps ok", 1, r.ok);
            chk("ps id", {8'h00, 16'h0010 + i[15:0], 8'h0c}, r.data);
        end
        @(negedge clock);
        chk("empty", 0, rsp_valid);
        $display("test fifo done");
    endtask

    always @(posedge clock)
    begin
        if (!srst && tx_valid && tx_ready)
        begin
            if (seen.size() == 0) seen_dest = tx_dest;
            seen.push_back(tx_tok);
        end
    end

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        results();
    end

    initial
    begin
        {srst, cmd_valid, rsp_ready, slow, nak} = 5'h10;
        cmd       = '0;
        n_errors  = 0;
        checks    = 0;
        repeat (20) @(negedge clock);
        chk("reset outs", 0, {cmd_ready, tx_valid, rx_ready, rsp_valid});
        srst <= 1'b0;
        t_tile();
        t_node();
        t_periph();
        t_noreply();
        t_fail();
        t_fifo();
        results();
    end
endmodule

// *** dv/crma_dev_model.sv ***
// behavioural configuration endpoint that answers request messages
`timescale 1ns/1ps
module crma_dev_model (
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire crma_pkg::crma_tok_s tx_tok,
    input  wire logic [31:0]         tx_dest,
    input  wire logic                tx_valid,
    output logic                     tx_ready,
    output crma_pkg::crma_tok_s      rx_tok,
    output logic                     rx_valid,
    input  wire logic                rx_ready,
    input  wire logic                slow,
    input  wire logic                nak
);
    crma_pkg::crma_tok_s q[$];
    logic [31:0]         mem [0:31];
    logic [31:0]         dest;
    logic                tn;

    // slow mode stalls the link every other cycle
    initial
    begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_tok   = '0;
    end
    always @(negedge clock) tx_ready <= !srst && (slow ? !tx_ready : 1'b1);

    // gather tokens; destination latched with the lead token
    always @(posedge clock)
    begin
        if (!srst && tx_valid && tx_ready)
        begin
            if (q.size() == 0) dest = tx_dest;
            q.push_back(tx_tok);
        end
    end

    // one token held until the controller takes it
    task automatic send(input logic c, input logic [7:0] v);
        @(negedge clock);
        rx_tok   <= '{ctrl: c, val: v};
        rx_valid <= 1'b1;
        @(posedge clock);
        while (!rx_ready) @(posedge clock);
    endtask

    // released line shows the inverse, never a stale copy
    task automatic answer(input logic ok, input logic [31:0] d, input int nb);
        send(1'b1, ok ? crma_pkg::TOK_ACK : crma_pkg::TOK_NAK);
        if (ok) for (int i = nb - 1; i >= 0; i--) send(1'b0, d[8*i +: 8]);
        send(1'b1, crma_pkg::TOK_END);
        @(negedge clock);
        rx_valid <= 1'b0;
        rx_tok   <= crma_pkg::crma_tok_s'(~rx_tok);
    endtask

    // decode a message once its closing token has arrived
    initial forever
    begin
        @(negedge clock);
        if (q.size() > 1 && q[q.size()-1].ctrl === 1'b1 && q[q.size()-1].val === crma_pkg::TOK_END)
        begin
            tn = dest[15:0] == crma_pkg::TILE_PORT || dest[15:0] == crma_pkg::NODE_PORT;
            if (q[0].val == crma_pkg::TOK_WR && q.size() == 11 && tn)
            begin
                mem[{dest[8], q[5].val[3:0]}] = {q[6].val, q[7].val, q[8].val, q[9].val};
                if (q[3].val != crma_pkg::NO_REPLY) answer(!nak, 32'h0, 0);
            end
            else if (q[0].val == crma_pkg::TOK_RD && q.size() == 7 && tn)
                answer(!nak, mem[{dest[8], q[5].val[3:0]}], 4);
            else if (q[0].val == crma_pkg::TOK_PRD && q.size() == 7 && dest[7:0] == crma_pkg::PER_PORT)
                answer(!nak, {4{q[4].val}} ^ 32'h00010203, q[5].val);
            else
                answer(1'b0, 32'h0, 0);
            q.delete();
        end
    end
endmodule

// *** verilog/crma_ctrl.sv ***
// host controller issuing configuration request messages and collecting answers
`timescale 1ns/1ps
module crma_ctrl (
    input  wire logic                 clock,
    input  wire logic                 srst,
    input  wire crma_pkg::crma_cmd_s  cmd,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    output crma_pkg::crma_tok_s       tx_tok,
    output logic [31:0]               tx_dest,
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    input  wire crma_pkg::crma_tok_s  rx_tok,
    input  wire logic                 rx_valid,
    output logic                      rx_ready,
    output crma_pkg::crma_res_s       rsp,
    output logic                      rsp_valid,
    input  wire logic                 rsp_ready
);
    typedef enum {S_IDLE, S_SEND, S_HDR, S_DATA, S_END, S_PUSH} crma_state_e;

    crma_state_e          st_q, st_d;
    crma_pkg::crma_cmd_s  c_q, c_d;
    crma_pkg::crma_tok_s  tok_q, tok_d;
    logic [31:0]          dest_q, dest_d, acc_q, acc_d;
    logic [3:0]           idx_q, idx_d;
    logic [7:0]           nb_q, nb_d;
    logic                 tv_q, tv_d, rr_q, rr_d, cr_q, cr_d, ok_q, ok_d;
    logic                 fifo_rdy, rx_fire, cmd_fire;

    // ------------------------------------------------------------
    // message helpers
    // ------------------------------------------------------------
    function automatic logic is_wr(crma_pkg::crma_op_e op);
        return op == crma_pkg::OP_TILE_WR || op == crma_pkg::OP_NODE_WR;
    endfunction

    function automatic logic [3:0] msg_len(crma_pkg::crma_op_e op);
        return is_wr(op) ? crma_pkg::WR_LEN : crma_pkg::RD_LEN;
    endfunction

    // endpoint address of the configuration channel-end
    function automatic logic [31:0] dest_of(crma_pkg::crma_cmd_s c);
        case (c.op)
            crma_pkg::OP_TILE_WR, crma_pkg::OP_TILE_RD: return {c.target, crma_pkg::TILE_PORT};
            crma_pkg::OP_NODE_WR, crma_pkg::OP_NODE_RD: return {c.target, crma_pkg::NODE_PORT};
            default: return {c.target, c.periph, crma_pkg::PER_PORT};
        endcase
    endfunction

    // token i of the request, every field sent most significant byte first
    function automatic crma_pkg::crma_tok_s tok_at(crma_pkg::crma_cmd_s c, logic [3:0] i);
        crma_pkg::crma_tok_s t;
        logic                per;
        t   = '{ctrl: 1'b1, val: crma_pkg::TOK_END};
        per = (c.op == crma_pkg::OP_PER_RD);
        case (i)
            4'h0: t.val = per ? crma_pkg::TOK_PRD : (is_wr(c.op) ? crma_pkg::TOK_WR : crma_pkg::TOK_RD);
            4'h1: t = '{ctrl: 1'b0, val: c.reply_id[23:16]};
            4'h2: t = '{ctrl: 1'b0, val: c.reply_id[15:8]};
            4'h3: t = '{ctrl: 1'b0, val: c.reply_id[7:0]};
            4'h4: t = '{ctrl: 1'b0, val: per ? c.regnum[7:0] : c.regnum[15:8]};
            4'h5: t = '{ctrl: 1'b0, val: per ? c.size : c.regnum[7:0]};
            4'h6: if (is_wr(c.op)) t = '{ctrl: 1'b0, val: c.data[31:24]};
            4'h7: t = '{ctrl: 1'b0, val: c.data[23:16]};
            4'h8: t = '{ctrl: 1'b0, val: c.data[15:8]};
            4'h9: t = '{ctrl: 1'b0, val: c.data[7:0]};
            default: t = '{ctrl: 1'b1, val: crma_pkg::TOK_END};
        endcase
        return t;
    endfunction

    assign cmd_fire = cmd_valid && cr_q;
    assign rx_fire  = rx_valid && rr_q;

    // ------------------------------------------------------------
    // sequencer: next values
    // ------------------------------------------------------------
    // a new command is taken only in idle, so a full answer fifo stalls the requester
    always_comb
    begin
        st_d   = st_q;
        c_d    = c_q;
        tok_d  = tok_q;
        dest_d = dest_q;
        acc_d  = acc_q;
        idx_d  = idx_q;
        nb_d   = nb_q;
        tv_d   = tv_q;
        ok_d   = ok_q;
        case (st_q)
            S_IDLE:
                if (cmd_fire)
                begin
                    c_d   = cmd;
                    acc_d = '0;
                    nb_d  = '0;
                    if (cmd.op == crma_pkg::OP_PS_ID)
                    begin
                        // resource naming needs no link traffic
                        acc_d = {8'h00, cmd.regnum, crma_pkg::PS_TAG};
                        ok_d  = 1'b1;
                        st_d  = S_PUSH;
                    end
                    else if (cmd.op > crma_pkg::OP_PS_ID)
                    begin
                        ok_d = 1'b0;
                        st_d = S_PUSH;
                    end
                    else
                    begin
                        tok_d  = tok_at(cmd, 4'h0);
                        dest_d = dest_of(cmd);
                        tv_d   = 1'b1;
                        idx_d  = 4'h1;
                        st_d   = S_SEND;
                    end
                end
            S_SEND:
                if (tx_ready)
                begin
                    if (idx_q == msg_len(c_q.op))
                    begin
                        tv_d = 1'b0;
                        ok_d = 1'b0;
                        // suppressed write: the device stays silent, so do not wait
                        if (is_wr(c_q.op) && c_q.reply_id[7:0] == crma_pkg::NO_REPLY)
                            st_d = S_IDLE;
                        else
                            st_d = S_HDR;
                    end
                    else
                    begin
                        tok_d = tok_at(c_q, idx_q);
                        idx_d = 4'(idx_q + 1'b1);
                    end
                end
            S_HDR:
                if (rx_fire)
                begin
                    ok_d = rx_tok.ctrl && rx_tok.val == crma_pkg::TOK_ACK;
                    if (ok_d && !is_wr(c_q.op))
                        st_d = S_DATA;
                    else
                        st_d = S_END;
                end
            S_DATA:
                if (rx_fire)
                begin
                    if (!rx_tok.ctrl)
                    begin
                        acc_d = {acc_q[23:0], rx_tok.val};
                        nb_d  = 8'(nb_q + 1'b1);
                    end
                    else
                    begin
                        // wrong byte count or wrong closing token fails the read
                        ok_d = rx_tok.val == crma_pkg::TOK_END &&
                               nb_q == (c_q.op == crma_pkg::OP_PER_RD ? c_q.size : crma_pkg::WORD_BYTES);
                        st_d = (rx_tok.val == crma_pkg::TOK_END) ? S_PUSH : S_END;
                    end
                end
            S_END:
                if (rx_fire)
                begin
                    if (rx_tok.ctrl && rx_tok.val == crma_pkg::TOK_END)
                        st_d = S_PUSH;
                    else
                        ok_d = 1'b0;
                end
            S_PUSH:
                if (fifo_rdy)
                    st_d = S_IDLE;
            default:
                st_d = S_IDLE;
        endcase
        cr_d = (st_d == S_IDLE) && !cmd_fire;
        rr_d = (st_d == S_HDR) || (st_d == S_DATA) || (st_d == S_END);
    end

    // ------------------------------------------------------------
    // sequencer: registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_q   <= S_IDLE;
            c_q    <= '0;
            tok_q  <= '0;
            dest_q <= '0;
            acc_q  <= '0;
            idx_q  <= '0;
            nb_q   <= '0;
            tv_q   <= 1'b0;
            rr_q   <= 1'b0;
            cr_q   <= 1'b0;
            ok_q   <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            c_q    <= c_d;
            tok_q  <= tok_d;
            dest_q <= dest_d;
            acc_q  <= acc_d;
            idx_q  <= idx_d;
            nb_q   <= nb_d;
            tv_q   <= tv_d;
            rr_q   <= rr_d;
            cr_q   <= cr_d;
            ok_q   <= ok_d;
        end
    end

    assign cmd_ready = cr_q;
    assign tx_tok    = tok_q;
    assign tx_dest   = dest_q;
    assign tx_valid  = tv_q;
    assign rx_ready  = rr_q;

    // ------------------------------------------------------------
    // answer buffer
    // ------------------------------------------------------------
    crma_fifo #(
        .W ($bits(crma_pkg::crma_res_s)),
        .D (crma_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .srst      (srst),
        .in_data   ({ok_q, acc_q}),
        .in_valid  (st_q == S_PUSH),
        .in_ready  (fifo_rdy),
        .out_data  (rsp),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence take_s(crma_pkg::crma_op_e o);
        cmd_fire && cmd.op == o;
    endsequence

    wr_lead_a: assert property (take_s(crma_pkg::OP_TILE_WR) |=> tx_valid && tx_tok.ctrl && tx_tok.val == 8'hc0)
        else $error("write did not open with token 192");
    rd_lead_a: assert property (take_s(crma_pkg::OP_NODE_RD) |=> tx_valid && tx_tok.ctrl && tx_tok.val == 8'hc1)
        else $error("read did not open with token 193");
    per_lead_a: assert property (take_s(crma_pkg::OP_PER_RD) |=> tx_tok.val == 8'h25 && tx_dest[7:0] == 8'h02)
        else $error("peripheral read lead or address wrong");
    reply_msb_a: assert property (st_q == S_SEND && idx_q == 4'h2 |-> !tx_tok.ctrl && tx_tok.val == c_q.reply_id[23:16])
        else $error("reply identifier not sent msb first");
    tile_dest_a: assert property (tx_valid && c_q.op == crma_pkg::OP_TILE_RD |-> tx_dest[15:0] == 16'hc20c)
        else $error("tile destination wrong");
    msg_end_a: assert property (tx_valid && tx_ready && st_q == S_SEND && idx_q == msg_len(c_q.op)
        |-> tx_tok.ctrl && tx_tok.val == 8'h01)
        else $error("message not closed with token 1");
    no_reply_a: assert property (st_q == S_SEND && tx_ready && idx_q == msg_len(c_q.op) && is_wr(c_q.op)
        && c_q.reply_id[7:0] == 8'hff |=> st_q == S_IDLE && !rx_ready ##1 !rx_ready)
        else $error("suppressed write waited for an answer");
    nak_fail_a: assert property (st_q == S_HDR && rx_fire && rx_tok.ctrl && rx_tok.val == 8'h04
        ##1 rx_fire && rx_tok.ctrl && rx_tok.val == 8'h01 |=> st_q == S_PUSH && !ok_q)
        else $error("failure answer not reported as failed");
    ps_id_a: assert property (take_s(crma_pkg::OP_PS_ID) |=> acc_q == {8'h00, $past(cmd.regnum), 8'h0c})
        else $error("status resource identifier wrong");

endmodule

// *** verilog/crma_fifo.sv ***
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module crma_fifo #(
    parameter int W = 33,
    parameter int D = 8
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          full_q, full_d, empty_q, empty_d;
    logic          push, pop;
    logic [W-1:0]  dout_q, dout_d;

    // ------------------------------------------------------------
    // pointers and flags
    // ------------------------------------------------------------
    // flags are registered so that both ready and valid come straight from flops
    always_comb
    begin
        push    = in_valid && !full_q;
        pop     = out_ready && !empty_q;
        wr_d    = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d    = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d   = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        full_d  = (cnt_d == (AW+1)'(D));
        empty_d = (cnt_d == '0);
        // head word is registered; a push into the slot that becomes the head bypasses storage
        dout_d  = (push && wr_q == rd_d) ? in_data : mem_q[rd_d];
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
            dout_q  <= '0;
        end
        else
        begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            cnt_q   <= cnt_d;
            full_q  <= full_d;
            empty_q <= empty_d;
            dout_q  <= dout_d;
        end
    end

    // storage has no reset; only written words are ever shown
    always_ff @(posedge clock)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    assign in_ready  = !full_q;
    assign out_valid = !empty_q;
    assign out_data  = dout_q;

endmodule

// *** verilog/crma_pkg.sv ***
// constants, command and result types for the configuration message access controller
package crma_pkg;

    // ------------------------------------------------------------
    // control tokens and endpoint constants
    // ------------------------------------------------------------
    localparam logic [7:0]  TOK_WR      = 8'hc0;     // 192: tile/node write lead
    localparam logic [7:0]  TOK_RD      = 8'hc1;     // 193: tile/node read lead
    localparam logic [7:0]  TOK_PRD     = 8'h25;     // 37: peripheral read lead
    localparam logic [7:0]  TOK_ACK     = 8'h03;
    localparam logic [7:0]  TOK_NAK     = 8'h04;
    localparam logic [7:0]  TOK_END     = 8'h01;
    localparam logic [15:0] TILE_PORT   = 16'hc20c;
    localparam logic [15:0] NODE_PORT   = 16'hc30c;
    localparam logic [7:0]  PER_PORT    = 8'h02;
    localparam logic [7:0]  PS_TAG      = 8'h0c;
    localparam logic [7:0]  NO_REPLY    = 8'hff;     // low reply byte that suppresses a write answer
    localparam logic [3:0]  WR_LEN      = 4'hb;      // tokens in a write message
    localparam logic [3:0]  RD_LEN      = 4'h7;      // tokens in a read message
    localparam logic [7:0]  WORD_BYTES  = 8'h04;
    localparam int          FIFO_DEPTH  = 8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_TILE_WR,
        OP_TILE_RD,
        OP_NODE_WR,
        OP_NODE_RD,
        OP_PER_RD,
        OP_PS_ID
    } crma_op_e;

    typedef struct packed {
        crma_op_e    op;
        logic [15:0] target;    // tile or node identifier
        logic [7:0]  periph;    // peripheral identifier
        logic [23:0] reply_id;
        logic [15:0] regnum;
        logic [31:0] data;
        logic [7:0]  size;      // peripheral read length in bytes
    } crma_cmd_s;

    typedef struct packed {
        logic       ctrl;
        logic [7:0] val;
    } crma_tok_s;

    typedef struct packed {
        logic        ok;
        logic [31:0] data;
    } crma_res_s;

endpackage
